// ### serial_vid_plane_control_tb.sv
`timescale 1ns/100ps
`include "svpc_map.svh"

module serial_vid_plane_control_tb;
	logic       sys_clk            = 1'b0;
	logic       arst_n             = 1'b0;
	logic       enable_pin         = 1'b0;
	logic       processor_power_ok = 1'b0;
	logic       planes_in_reg      = 1'b1;
	logic [3:0] pwm_rise           = 4'h0;
	logic       link_clk;
	logic       link_frame;
	logic       serial_vid_data;
	logic [7:0] core_ref;
	logic [7:0] northbridge_ref;
	logic       planes_power_good;
	logic [3:0] phase_tristate;
	logic       power_save_allowed;
	logic [6:0] code;
	int         err_count   = 0;
	int         checks_done = 0;
	int         cycles      = 0;

	svpc_nb_model nbm (
		.link_clk        (link_clk),
		.link_frame      (link_frame),
		.serial_vid_data (serial_vid_data)
	);

	svpc_ctrl #(.PHASES(4)) uut (
		.sys_clk            (sys_clk),
		.arst_n             (arst_n),
		.link_clk           (link_clk),
		.serial_vid_data    (serial_vid_data),
		.serial_clk_pin     (link_clk),
		.link_frame         (link_frame),
		.enable_pin         (enable_pin),
		.processor_power_ok (processor_power_ok),
		.planes_in_reg      (planes_in_reg),
		.phase_count        (3'h4),
		.pwm_rise           (pwm_rise),
		.core_ref           (core_ref),
		.northbridge_ref    (northbridge_ref),
		.planes_power_good  (planes_power_good),
		.phase_tristate     (phase_tristate),
		.power_save_allowed (power_save_allowed)
	);

	initial forever #5 sys_clk = ~sys_clk;

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 50000) begin
			err_count++;
			tally_and_finish();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	function automatic logic [7:0] lvl(input logic [6:0] c);
		return (c >= `SVPC_VID_OFF_FIRST) ? `SVPC_LEVEL_ZERO : 8'(`SVPC_LEVEL_TOP - c);
	endfunction : lvl

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : wait_cyc

	task automatic cmd(input logic core, input logic nb, input logic ps, input logic [6:0] c);
		nbm.send(svpc_pkg::svpc_cmd_type'({core, nb, ps, c}));
		wait_cyc(10);
	endtask : cmd

	task automatic pulse(input int p, input logic [3:0] exp);
		@(posedge sys_clk);
		pwm_rise <= 4'(1 << p);
		@(posedge sys_clk);
		pwm_rise <= 4'h0;
		wait_cyc(1);
		chk("phase_tristate", {4'h0, exp}, {4'h0, phase_tristate});
	endtask : pulse

	task automatic shed();
		pulse(3, 4'h8);
		pulse(2, 4'hC);
		pulse(1, 4'hE);
	endtask : shed

	task automatic unshed();
		pulse(1, 4'hC);
		pulse(2, 4'h8);
		pulse(3, 4'h0);
	endtask : unshed

	initial begin
		void'($urandom(32'hDCCEA8A2));
		repeat (16) @(posedge sys_clk);
		#1;
		chk("reset_refs", 8'h00, core_ref | northbridge_ref);
		chk("reset_flags", 8'h00, {2'h0, phase_tristate, planes_power_good, power_save_allowed});
		@(posedge sys_clk);
		arst_n <= 1'b1;
		wait_cyc(4);
		@(posedge sys_clk);
		enable_pin <= 1'b1;
		// soft-start runs the full boot ramp, so the wait is long
		for (int i = 0; i < 30000 && planes_power_good !== 1'b1; i++)
			@(posedge sys_clk);
		wait_cyc(1);
		chk("core_ref", `SVPC_BOOT_LVL_11, core_ref);
		chk("northbridge_ref", `SVPC_BOOT_LVL_11, northbridge_ref);
		@(posedge sys_clk);
		processor_power_ok <= 1'b1;
		cmd(1'b1, 1'b1, 1'b0, 7'h3C);
		chk("power_save_allowed", 8'h01, {7'h0, power_save_allowed});
		pulse(1, 4'h0);
		shed();
		cmd(1'b1, 1'b1, 1'b0, 7'h3A);
		wait_cyc(2 * `SVPC_STEP_CYC + 40);
		chk("core_ref", lvl(7'h3C), core_ref);
		unshed();
		wait_cyc(2 * `SVPC_STEP_CYC + 40);
		chk("core_ref", lvl(7'h3A), core_ref);
		chk("northbridge_ref", lvl(7'h3A), northbridge_ref);
		shed();
		cmd(1'b1, 1'b1, 1'b1, 7'h3A);
		chk("power_save_allowed", 8'h00, {7'h0, power_save_allowed});
		pulse(3, 4'hE);
		unshed();
		cmd(1'b1, 1'b1, 1'b0, 7'h3A);
		chk("power_save_allowed", 8'h01, {7'h0, power_save_allowed});
		@(posedge sys_clk);
		processor_power_ok <= 1'b0;
		code = 7'($urandom_range(123));
		cmd(1'b1, 1'b1, 1'b0, code);
		wait_cyc(2 * `SVPC_STEP_CYC + 40);
		chk("core_ref", `SVPC_BOOT_LVL_11, core_ref);
		chk("northbridge_ref", `SVPC_BOOT_LVL_11, northbridge_ref);
		chk("power_save_allowed", 8'h00, {7'h0, power_save_allowed});
		@(posedge sys_clk);
		processor_power_ok <= 1'b1;
		wait_cyc(2 * `SVPC_STEP_CYC + 40);
		chk("core_ref", `SVPC_BOOT_LVL_11, core_ref);
		chk("power_save_allowed", 8'h00, {7'h0, power_save_allowed});
		code = 7'h7C + 7'($urandom_range(3));
		cmd(1'b1, 1'b0, 1'b1, code);
		wait_cyc(`SVPC_STEP_CYC + 40);
		chk("core_falling", 8'h01, {7'h0, core_ref < `SVPC_BOOT_LVL_11});
		chk("northbridge_ref", `SVPC_BOOT_LVL_11, northbridge_ref);
		chk("planes_power_good", 8'h01, {7'h0, planes_power_good});
		@(posedge sys_clk);
		planes_in_reg <= 1'b0;
		wait_cyc(`SVPC_STEP_CYC + 40);
		chk("planes_power_good", 8'h00, {7'h0, planes_power_good});
		chk("nb_falling", 8'h01, {7'h0, northbridge_ref < `SVPC_BOOT_LVL_11});
		tally_and_finish();
	end
endmodule : serial_vid_plane_control_tb

// ### svpc_ctrl.sv
// Function
// - While power-ok is high, watch the serial bus for set-VID commands.
// - Decode addressed plane or planes and the 7-bit voltage code.
// - Step each addressed plane reference to its new target; one or both.
// - Core plane commanded off keeps power-good asserted.
// - Power-ok low: both planes go to boot level; serial pins not sampled.
// - After power-ok returns, keep boot level until a new command.
// - Power-good loss ramps both plane references down to zero.
// - Code zero is highest level; each code lowers one step to code 7B.
// - Codes 7C through 7F switch the addressed plane off.
// - Command bit 7 is active-low power-save request.
// - Power-save: shed phase 4, then 3, then 2; phase 1 keeps switching.
// - A shed phase tri-states only when its PWM would next go high.
// - Leaving power-save while still running re-enables shed phases in order from phase 2.
// - While running, a re-enabled phase leaves tri-state only when its PWM goes high.
// - VID change in power-save: restore phases, slew, then shed again.
// - Enable rising edge latches two-bit boot code from serial pins.
// - Power-good rises at end of soft-start once both planes reach target.
// - References slew one step at a fixed rate until equal to target.
`timescale 1ns/100ps
`include "svpc_map.svh"

module svpc_ctrl #(
	parameter int PHASES = 4
) (
	input  wire logic        sys_clk,            // system clock 100 MHz
	input  wire logic        arst_n,             // async reset, low
	input  wire logic        link_clk,           // serial vid clock
	input  wire logic        serial_vid_data,    // serial data pin
	input  wire logic        serial_clk_pin,     // serial clock pin level
	input  wire logic        link_frame,         // frame active, link domain
	input  wire logic        enable_pin,         // regulator enable
	input  wire logic        processor_power_ok, // power-ok handshake
	input  wire logic        planes_in_reg,      // both planes in regulation
	input  wire logic [2:0]  phase_count,        // fitted phases, 2 to 4
	input  wire logic [3:0]  pwm_rise,           // per-phase pwm high start
	output logic [7:0]       core_ref,           // core dac level
	output logic [7:0]       northbridge_ref,    // northbridge dac level
	output logic             planes_power_good,  // power good
	output logic [3:0]       phase_tristate,     // per-phase tri-state
	output logic             power_save_allowed  // latched request state
);

	localparam logic [8:0] STEP_LAST = 9'(`SVPC_STEP_CYC - 1);

	// pin synchronisers: en, ok, clk pin, data pin, command toggle
	logic [4:0]                 sync1_q;
	logic [4:0]                 sync2_q;
	logic                       en_s3_q;
	logic                       tog_s3_q;
	logic                       en_s;
	logic                       ok_s;
	logic                       en_rise;
	logic                       cmd_evt;
	logic                       link_tog;
	svpc_pkg::svpc_cmd_type     link_cmd;

	svpc_pkg::svpc_state_type   st_q;
	svpc_pkg::svpc_state_type   st_d;
	logic [7:0]                 core_ref_q;
	logic [7:0]                 core_ref_d;
	logic [7:0]                 nb_ref_q;
	logic [7:0]                 nb_ref_d;
	logic [7:0]                 core_tgt_q;
	logic [7:0]                 core_tgt_d;
	logic [7:0]                 nb_tgt_q;
	logic [7:0]                 nb_tgt_d;
	logic [7:0]                 boot_q;
	logic [7:0]                 boot_d;
	logic                       pg_q;
	logic                       pg_d;
	logic                       psave_n_q;
	logic                       psave_n_d;
	logic                       allow_q;
	logic [8:0]                 tmr_q;
	logic [8:0]                 tmr_d;
	logic [3:0]                 tri_q;
	logic [3:0]                 tri_d;
	logic                       tick;
	logic                       save_want;
	logic [7:0]                 cmd_lvl;

	assign en_s    = sync2_q[0];
	assign ok_s    = sync2_q[1];
	assign en_rise = en_s & ~en_s3_q;
	assign cmd_evt = sync2_q[4] ^ tog_s3_q;
	assign tick    = (tmr_q == STEP_LAST);

	svpc_link_rx u_link (
		.link_clk        (link_clk),
		.arst_n          (arst_n),
		.serial_vid_data (serial_vid_data),
		.link_frame      (link_frame),
		.power_ok_sys    (ok_s),
		.cmd_q           (link_cmd),
		.cmd_tog_q       (link_tog)
	);

	// code to level, top codes mean off
	always_comb begin
		if (link_cmd.voltage_id_code >= `SVPC_VID_OFF_FIRST) begin
			cmd_lvl = `SVPC_LEVEL_ZERO;
		end else begin
			cmd_lvl = `SVPC_LEVEL_TOP - {1'b0, link_cmd.voltage_id_code};
		end
	end

	// sheds only when settled, so a new target first restores phases
	assign save_want = (st_q == svpc_pkg::ST_RUN) && !psave_n_q
	                   && (core_ref_q == core_tgt_q) && (nb_ref_q == nb_tgt_q);

	always_comb begin
		st_d       = st_q;
		core_tgt_d = core_tgt_q;
		nb_tgt_d   = nb_tgt_q;
		boot_d     = boot_q;
		pg_d       = pg_q;
		psave_n_d  = psave_n_q;
		tmr_d      = tick ? 9'h000 : tmr_q + 9'h001;
		core_ref_d = core_ref_q;
		nb_ref_d   = nb_ref_q;
		case (st_q)
			svpc_pkg::ST_OFF: begin
				pg_d = 1'b0;
				if (en_rise) begin
					case ({sync2_q[2], sync2_q[3]})
						2'b00:   boot_d = `SVPC_BOOT_LVL_00;
						2'b01:   boot_d = `SVPC_BOOT_LVL_01;
						2'b10:   boot_d = `SVPC_BOOT_LVL_10;
						default: boot_d = `SVPC_BOOT_LVL_11;
					endcase
					core_tgt_d = boot_d;
					nb_tgt_d   = boot_d;
					st_d       = svpc_pkg::ST_SOFT;
				end
			end
			svpc_pkg::ST_SOFT: begin
				if (!en_s) begin
					core_tgt_d = `SVPC_LEVEL_ZERO;
					nb_tgt_d   = `SVPC_LEVEL_ZERO;
					st_d       = svpc_pkg::ST_DOWN;
				end else if (core_ref_q == core_tgt_q && nb_ref_q == nb_tgt_q) begin
					pg_d = 1'b1;
					st_d = svpc_pkg::ST_RUN;
				end
			end
			svpc_pkg::ST_RUN: begin
				// core off by command does not touch power good
				if (!en_s || !planes_in_reg) begin
					pg_d       = 1'b0;
					core_tgt_d = `SVPC_LEVEL_ZERO;
					nb_tgt_d   = `SVPC_LEVEL_ZERO;
					psave_n_d  = 1'b1;
					st_d       = svpc_pkg::ST_DOWN;
				end else if (!ok_s) begin
					core_tgt_d = boot_q;
					nb_tgt_d   = boot_q;
					psave_n_d  = 1'b1;
				end else if (cmd_evt) begin
					psave_n_d = link_cmd.power_save_request_n;
					if (link_cmd.core_sel) begin
						core_tgt_d = cmd_lvl;
					end
					if (link_cmd.nb_sel) begin
						nb_tgt_d = cmd_lvl;
					end
				end
			end
			default: begin
				pg_d       = 1'b0;
				core_tgt_d = `SVPC_LEVEL_ZERO;
				nb_tgt_d   = `SVPC_LEVEL_ZERO;
				if (core_ref_q == `SVPC_LEVEL_ZERO && nb_ref_q == `SVPC_LEVEL_ZERO) begin
					st_d = svpc_pkg::ST_OFF;
				end
			end
		endcase
		// one step per tick; frozen in run while any phase is still shed
		if (tick && (st_q != svpc_pkg::ST_RUN || tri_q == 4'h0)) begin
			if (core_ref_q < core_tgt_q) begin
				core_ref_d = core_ref_q + 8'h01;
			end else if (core_ref_q > core_tgt_q) begin
				core_ref_d = core_ref_q - 8'h01;
			end
			if (nb_ref_q < nb_tgt_q) begin
				nb_ref_d = nb_ref_q + 8'h01;
			end else if (nb_ref_q > nb_tgt_q) begin
				nb_ref_d = nb_ref_q - 8'h01;
			end
		end
	end

	// phase shedding in run, one phase at a time, switched only at pwm rise; all cleared at once outside run
	always_comb begin
		logic found;
		found = 1'b0;
		tri_d = tri_q;
		if (st_q != svpc_pkg::ST_RUN) begin
			tri_d = 4'h0;
		end else if (save_want) begin
			for (int i = 3; i >= 1; i--) begin
				if (!found && i < PHASES && 3'(i) < phase_count && !tri_q[i]) begin
					found = 1'b1;
					if (pwm_rise[i]) begin
						tri_d[i] = 1'b1;
					end
				end
			end
		end else begin
			for (int i = 1; i <= 3; i++) begin
				if (!found && tri_q[i]) begin
					found = 1'b1;
					if (pwm_rise[i]) begin
						tri_d[i] = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q    <= 5'h00;
			sync2_q    <= 5'h00;
			en_s3_q    <= 1'b0;
			tog_s3_q   <= 1'b0;
			st_q       <= svpc_pkg::ST_OFF;
			core_ref_q <= `SVPC_LEVEL_ZERO;
			nb_ref_q   <= `SVPC_LEVEL_ZERO;
			core_tgt_q <= `SVPC_LEVEL_ZERO;
			nb_tgt_q   <= `SVPC_LEVEL_ZERO;
			boot_q     <= `SVPC_LEVEL_ZERO;
			pg_q       <= 1'b0;
			psave_n_q  <= 1'b1;
			allow_q    <= 1'b0;
			tmr_q      <= 9'h000;
			tri_q      <= 4'h0;
		end else begin
			sync1_q    <= {link_tog, serial_vid_data, serial_clk_pin,
			               processor_power_ok, enable_pin};
			sync2_q    <= sync1_q;
			en_s3_q    <= sync2_q[0];
			tog_s3_q   <= sync2_q[4];
			st_q       <= st_d;
			core_ref_q <= core_ref_d;
			nb_ref_q   <= nb_ref_d;
			core_tgt_q <= core_tgt_d;
			nb_tgt_q   <= nb_tgt_d;
			boot_q     <= boot_d;
			pg_q       <= pg_d;
			psave_n_q  <= psave_n_d;
			// own flop so the pin carries no gate after the register
			allow_q    <= ~psave_n_d;
			tmr_q      <= tmr_d;
			tri_q      <= tri_d;
		end
	end

	assign core_ref           = core_ref_q;
	assign northbridge_ref    = nb_ref_q;
	assign planes_power_good  = pg_q;
	assign phase_tristate     = tri_q;
	assign power_save_allowed = allow_q;

	AST_VID_LINEAR: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_q == svpc_pkg::ST_RUN && en_s && planes_in_reg && ok_s && cmd_evt
		 && link_cmd.core_sel && link_cmd.voltage_id_code < 7'h7C)
		|=> core_tgt_q == 8'h7C - {1'b0, $past(link_cmd.voltage_id_code)})
		else $error("core target does not follow code linearly");

	AST_VID_OFF: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_q == svpc_pkg::ST_RUN && en_s && planes_in_reg && ok_s && cmd_evt
		 && link_cmd.core_sel && link_cmd.voltage_id_code >= 7'h7C)
		|=> core_tgt_q == 8'h00)
		else $error("off code did not switch plane off");

	AST_BOOT_FALLBACK: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_q == svpc_pkg::ST_RUN && en_s && planes_in_reg && !ok_s)
		|=> core_tgt_q == boot_q && nb_tgt_q == boot_q && psave_n_q)
		else $error("planes not returned to boot level");

	AST_PG_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(pg_q && st_q == svpc_pkg::ST_RUN && en_s && planes_in_reg) |=> pg_q)
		else $error("power good dropped while enabled and in regulation");

	AST_RAMP_DOWN: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_q == svpc_pkg::ST_RUN && !planes_in_reg)
		|=> !pg_q && core_tgt_q == 8'h00 && nb_tgt_q == 8'h00 ##1 st_q == svpc_pkg::ST_DOWN
		|| st_q == svpc_pkg::ST_OFF)
		else $error("power good loss did not start ramp down");

	AST_SLEW_STEP: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(core_ref_q != $past(core_ref_q)) |-> $past(tick)
		&& (core_ref_q == $past(core_ref_q) + 8'h01 || core_ref_q == $past(core_ref_q) - 8'h01))
		else $error("reference moved off the slew tick or by more than one step");

	AST_SHED_ON_RISE: assert property (@(posedge sys_clk) disable iff (!arst_n)
		((tri_q & ~$past(tri_q) & ~$past(pwm_rise)) == 4'h0))
		else $error("phase tri-stated without its pwm rise");

	AST_UNSHED_ON_RISE: assert property (@(posedge sys_clk) disable iff (!arst_n)
		($past(st_q) == svpc_pkg::ST_RUN) |->
		((~tri_q & $past(tri_q) & ~$past(pwm_rise)) == 4'h0))
		else $error("phase left tri-state without its pwm rise");

	AST_PHASE1_ON: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!tri_q[0]
		&& ($past(st_q) != svpc_pkg::ST_RUN || $countones(tri_q ^ $past(tri_q)) <= 1))
		else $error("phase 1 shed or several phases switched at once");

	AST_RESTORE_FIRST: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_q == svpc_pkg::ST_RUN && tri_q != 4'h0) |=> core_ref_q == $past(core_ref_q))
		else $error("reference moved while phases were shed");

	AST_PG_SOFTSTART: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$rose(pg_q) |-> $past(st_q) == svpc_pkg::ST_SOFT
		&& core_ref_q == boot_q && nb_ref_q == boot_q)
		else $error("power good rose before soft-start finished");

	COV_SOFTSTART: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(pg_q));
	COV_ALL_SHED: cover property (@(posedge sys_clk) disable iff (!arst_n) tri_q == 4'hE);
	COV_CORE_OFF: cover property (@(posedge sys_clk) disable iff (!arst_n)
		pg_q && core_tgt_q == 8'h00 && nb_tgt_q != 8'h00);
	COV_BOOT_FALLBACK: cover property (@(posedge sys_clk) disable iff (!arst_n)
		st_q == svpc_pkg::ST_RUN && !ok_s && core_tgt_q == boot_q);
	COV_RESTORED: cover property (@(posedge sys_clk) disable iff (!arst_n)
		st_q == svpc_pkg::ST_RUN && tri_q == 4'h0 && $past(tri_q) == 4'h8);

	AST_NB_LINEAR: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(st_q == svpc_pkg::ST_RUN && en_s && planes_in_reg && ok_s && cmd_evt
		 && link_cmd.nb_sel && link_cmd.voltage_id_code < 7'h7C)
		|=> nb_tgt_q == 8'h7C - {1'b0, $past(link_cmd.voltage_id_code)})
		else $error("northbridge target does not follow its code");

	// order checks need no phase count: a lower shed bit
	// must never be set before a higher one, nor cleared after it
	AST_SHED_ORDER: assert property (@(posedge sys_clk) disable iff (!arst_n)
		((tri_q & ~$past(tri_q)) != 4'h0)
		|-> ($past(tri_q) & ((tri_q & ~$past(tri_q)) - 4'h1) & 4'hE) == 4'h0)
		else $error("phase shed while a lower phase was already shed");

	AST_RESTORE_ORDER: assert property (@(posedge sys_clk) disable iff (!arst_n)
		($past(st_q) == svpc_pkg::ST_RUN && (~tri_q & $past(tri_q)) != 4'h0)
		|-> ($past(tri_q) & ((~tri_q & $past(tri_q)) - 4'h1) & 4'hE) == 4'h0)
		else $error("phase restored before a lower shed phase");

endmodule : svpc_ctrl

// ### svpc_link_rx.sv
`timescale 1ns/100ps
`include "svpc_map.svh"

module svpc_link_rx (
	input  wire logic             link_clk,        // serial vid clock
	input  wire logic             arst_n,          // async reset, low
	input  wire logic             serial_vid_data, // serial data pin
	input  wire logic             link_frame,      // frame active, high
	input  wire logic             power_ok_sys,    // power-ok from sys domain
	output svpc_pkg::svpc_cmd_type cmd_q,          // last complete command
	output logic                  cmd_tog_q        // flips per command
);

	logic                   ok_s1_q;
	logic                   ok_s2_q;
	logic [8:0]             shift_q;
	logic [8:0]             shift_d;
	logic [3:0]             cnt_q;
	logic [3:0]             cnt_d;
	svpc_pkg::svpc_cmd_type cmd_d;
	logic                   tog_d;

	always_comb begin
		shift_d = shift_q;
		cnt_d   = cnt_q;
		cmd_d   = cmd_q;
		tog_d   = cmd_tog_q;
		// no bits taken while power-ok is low
		if (!link_frame || !ok_s2_q) begin
			cnt_d = 4'h0;
		end else if (cnt_q == `SVPC_FRAME_BITS - 4'h1) begin
			// word held until the next frame ends, so the toggle crossing is safe
			cmd_d = svpc_pkg::svpc_cmd_type'({shift_q, serial_vid_data});
			tog_d = ~cmd_tog_q;
			cnt_d = 4'h0;
		end else begin
			shift_d = {shift_q[7:0], serial_vid_data};
			cnt_d   = cnt_q + 4'h1;
		end
	end

	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			ok_s1_q   <= 1'b0;
			ok_s2_q   <= 1'b0;
			shift_q   <= 9'h000;
			cnt_q     <= 4'h0;
			cmd_q     <= '0;
			cmd_tog_q <= 1'b0;
		end else begin
			ok_s1_q   <= power_ok_sys;
			ok_s2_q   <= ok_s1_q;
			shift_q   <= shift_d;
			cnt_q     <= cnt_d;
			cmd_q     <= cmd_d;
			cmd_tog_q <= tog_d;
		end
	end

endmodule : svpc_link_rx

// ### svpc_map.svh
`ifndef SVPC_MAP_SVH
`define SVPC_MAP_SVH

// reference levels are counts of one 12.5 mV step
`define SVPC_LEVEL_TOP      8'h7C
`define SVPC_VID_OFF_FIRST  7'h7C
`define SVPC_BOOT_LVL_00    8'h58
`define SVPC_BOOT_LVL_01    8'h50
`define SVPC_BOOT_LVL_10    8'h48
`define SVPC_BOOT_LVL_11    8'h40
`define SVPC_LEVEL_ZERO     8'h00

// slew timing
`define SVPC_STEP_UV        12500
`define SVPC_SLEW_UV_PER_US 3250
`define SVPC_CLK_NS         10
`define SVPC_STEP_CYC       ((`SVPC_STEP_UV * 1000 + `SVPC_SLEW_UV_PER_US * `SVPC_CLK_NS - 1) \
                             / (`SVPC_SLEW_UV_PER_US * `SVPC_CLK_NS))

// command frame: core select, nb select, power-save bit, 7-bit code
`define SVPC_FRAME_BITS     4'hA

`endif

// ### svpc_nb_model.sv
`timescale 1ns/100ps

module svpc_nb_model (
	output logic link_clk,        // serial clock wire, high and still between commands
	output logic link_frame,      // frame active
	output logic serial_vid_data  // serial data wire
);
	initial begin
		link_clk        = 1'b1; // idle high straps the boot code
		link_frame      = 1'b0;
		serial_vid_data = 1'b1;
		// two link edges inside reset for the link-side flops
		repeat (2) begin
			#40 link_clk = 1'b0;
			#40 link_clk = 1'b1;
		end
	end

	// ten idle clocks first: power-ok only resyncs on link edges
	task automatic send(input svpc_pkg::svpc_cmd_type c);
		#3.3 link_clk = 1'b0;
		for (int i = 19; i >= 0; i--) begin
			link_frame      = (i < 10);
			serial_vid_data = (i < 10) ? c[i] : ~serial_vid_data;
			#40 link_clk = 1'b1;
			#40 link_clk = 1'b0;
		end
		link_frame      = 1'b0;
		serial_vid_data = ~serial_vid_data;
		#40 link_clk = 1'b1;
	endtask : send
endmodule : svpc_nb_model

// ### svpc_pkg.sv
package svpc_pkg;

	typedef struct packed {
		logic       core_sel;
		logic       nb_sel;
		logic       power_save_request_n;
		logic [6:0] voltage_id_code;
	} svpc_cmd_type;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_SOFT,
		ST_RUN,
		ST_DOWN
	} svpc_state_type;

endpackage : svpc_pkg
